// ==== design/sfcl_pkg.sv ====
package sfcl_pkg;

   // serial word
   localparam int WORD_W = 24;
   localparam int SEL2_W = 2;
   localparam int SEL3_W = 3;
   localparam logic [1:0] SEL2_CONTROL = 2'h0;
   localparam logic [1:0] SEL2_LO = 2'h2;
   localparam logic [2:0] SEL3_TX = 3'h1;
   localparam logic [2:0] SEL3_CAL = 3'h5;

   // synchroniser lanes
   localparam int SER_CLK = 0;
   localparam int SER_DAT = 1;
   localparam int SER_LE = 2;
   localparam int PIN_LOCK = 0;
   localparam int PIN_REF = 1;
   localparam int PIN_MAN = 2;
   localparam int PIN_N = 3;

   // control latch fields
   localparam int CTL_SPARE_LO = 2;
   localparam int CTL_SPARE_HI = 3;
   localparam int CTL_HOLD = 4;
   localparam int CTL_POL = 5;
   localparam int CTL_TRI = 6;
   localparam int CTL_TXMUTE = 7;
   localparam int CTL_LOMUTE = 8;
   localparam int CTL_MUX = 9;
   localparam int MUX_W = 3;
   localparam int CTL_CPI = 12;
   localparam int CPI_W = 3;
   localparam int CTL_TXPWR = 15;
   localparam int CTL_LOPWR = 17;
   localparam int PWR_W = 2;
   localparam int CTL_TX_OFF = 19;
   localparam int CTL_OSC_OFF = 20;
   localparam int CTL_SYN_OFF = 21;
   localparam int CTL_RXF_OFF = 22;

   // fields shared by transmit and calibration latches
   localparam int PH_POS = 21;
   localparam int PH_W = 3;
   localparam int TMOD_POS = 18;
   localparam int TMOD_W = 3;
   localparam int BSC_POS = 16;
   localparam int BSC_W = 2;

   // transmit latch
   localparam int TX_REF_POS = 3;
   localparam int REF_W = 13;

   // calibration latch
   localparam int CAL_TO_POS = 3;
   localparam int CAL_TO_W = 6;
   localparam int CAL_DIV_POS = 9;
   localparam int CAL_DIV_W = 6;
   localparam int CAL_TRIG = 15;

   // local oscillator latch
   localparam int LO_A_POS = 2;
   localparam int A_W = 5;
   localparam int LO_B_POS = 7;
   localparam int B_W = 13;
   localparam int LO_FB = 20;
   localparam int LO_GAIN = 21;
   localparam int LO_PRE_POS = 22;
   localparam int PRE_W = 2;

   // codes
   localparam logic [2:0] RX_LO_OFF = 3'h7;
   localparam logic [2:0] TMOD_BOTH_I = 3'h1;
   localparam logic [2:0] TMOD_BOTH_Q = 3'h2;
   localparam logic [2:0] CPI_MAX = 3'h7;
   localparam logic MIX_I = 1'b0;
   localparam logic MIX_Q = 1'b1;

   typedef enum logic [1:0] {
      BOOST_IDLE = 2'h1,
      BOOST_RUN = 2'h2
   } sfcl_boost_t;

   // level changes once the second and third stage agree
   function automatic logic [2:0] agree_level(input logic [2:0] s2,
                                             input logic [2:0] s3,
                                             input logic [2:0] held);
      return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & held);
   endfunction

endpackage

// ==== design/sfcl_word_if.sv ====
interface sfcl_word_if;
   import sfcl_pkg::*;
   logic [WORD_W-1:0] word;
   logic load;
   modport source (output word, output load);
   modport sink (input word, input load);
endinterface

// ==== design/sfcl_serial_rx.sv ====
module sfcl_serial_rx
   import sfcl_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic load_enable,
   sfcl_word_if.source word_port
);

   logic [2:0] ser_s1_ff;
   logic [2:0] ser_s2_ff;
   logic [2:0] ser_s3_ff;
   logic [2:0] ser_lvl_ff;
   logic [2:0] nxt_ser_lvl;
   logic [2:0] ser_rise;
   logic [WORD_W-1:0] shift_ff;
   logic [WORD_W-1:0] nxt_shift;
   logic [WORD_W-1:0] word_ff;
   logic [WORD_W-1:0] nxt_word;
   logic load_ff;
   logic nxt_load;

   // shift msb first, copy out on load strobe
   always_comb begin
      nxt_ser_lvl = agree_level(ser_s2_ff, ser_s3_ff, ser_lvl_ff);
      ser_rise = nxt_ser_lvl & ~ser_lvl_ff;
      nxt_shift = shift_ff;
      if (ser_rise[SER_CLK]) begin
         nxt_shift = {shift_ff[WORD_W-2:0], nxt_ser_lvl[SER_DAT]};
      end
      nxt_load = ser_rise[SER_LE];
      nxt_word = ser_rise[SER_LE] ? shift_ff : word_ff;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ser_s1_ff <= '0;
         ser_s2_ff <= '0;
         ser_s3_ff <= '0;
         ser_lvl_ff <= '0;
         shift_ff <= '0;
         word_ff <= '0;
         load_ff <= 1'b0;
      end else begin
         ser_s1_ff <= {load_enable, serial_in, serial_clock};
         ser_s2_ff <= ser_s1_ff;
         ser_s3_ff <= ser_s2_ff;
         ser_lvl_ff <= nxt_ser_lvl;
         shift_ff <= nxt_shift;
         word_ff <= nxt_word;
         load_ff <= nxt_load;
      end
   end

   assign word_port.word = word_ff;
   assign word_port.load = load_ff;

   a_load_word_copy: assert property (
      @(posedge clock) disable iff (!reset_n)
      load_ff |-> word_ff == $past(shift_ff))
      else $error("loaded word differs from shift register");

   a_load_single_pulse: assert property (
      @(posedge clock) disable iff (!reset_n)
      load_ff |=> !load_ff)
      else $error("load strobe longer than one cycle");

endmodule

// ==== design/sfcl_latches.sv ====
// Function
// - word with low select bits 00 loads the control latch.
// - four power-down bits power down rx filter, synth, oscillator, transmit.
// - lo mute bit keeps lo outputs off until pll lock.
// - tx mute bit keeps transmit outputs off until pll lock.
// - pump tristate bit 1 floats charge pump, 0 normal.
// - phase polarity 1 positive; host uses 0 with inverting filter.
// - counter hold 1 holds reference, a and b counters in reset.
// - word with low select bits 001 loads the transmit latch.
// - rx lo phase field steps quarter cycles; one code disables output.
// - tx modulation field picks quadrature or one phase to both mixers.
// - thirteen-bit reference divider 1 to 8191; host never writes zero.
// - word with low select bits 101 loads the calibration latch.
// - calibration latch write with trigger set starts filter calibration.
// - six-bit divider divides reference input for calibration clock, 2 MHz.
// - boost lasts timeout value times divided calibration clock period.
// - zero timeout leaves boost to manual bit, host clears it.
// - word with low select bits 10 loads local_osc_latch; prescaler field.
// - pump gain 0 uses programmed current, 1 uses maximum.
// - feedback select 0 routes vco to n divider, 1 the mux.
// - thirteen-bit b counter field 3 to 8191.
// - five-bit a counter field 0 to 31.
module sfcl_latches
   import sfcl_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic load_enable,
   input wire logic pll_lock,
   input wire logic reference_input,
   input wire logic boost_manual,
   output logic rx_filter_powerdown,
   output logic synth_powerdown,
   output logic oscillator_powerdown,
   output logic transmit_powerdown,
   output logic lo_output_enable,
   output logic tx_output_enable,
   output logic pump_tristate,
   output logic phase_polarity,
   output logic counter_hold,
   output logic [2:0] mux_select,
   output logic [1:0] tx_power_level,
   output logic [1:0] lo_power_level,
   output logic [2:0] rx_lo_phase_field,
   output logic tx_mix_i_phase,
   output logic tx_mix_q_phase,
   output logic [1:0] band_clock_divider,
   output logic [12:0] reference_divider,
   output logic calibration_start,
   output logic calibration_clock_tick,
   output logic boost_active,
   output logic [1:0] prescaler_select,
   output logic [2:0] pump_current,
   output logic feedback_select,
   output logic [12:0] b_counter_field,
   output logic [4:0] a_counter_field
);

   sfcl_word_if word_bus ();

   sfcl_serial_rx u_rx (
      .clock(clock),
      .reset_n(reset_n),
      .serial_clock(serial_clock),
      .serial_in(serial_in),
      .load_enable(load_enable),
      .word_port(word_bus)
   );

   // pin synchronisers
   logic [PIN_N-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_lvl_ff;
   logic [PIN_N-1:0] nxt_pin_lvl;

   always_comb begin
      nxt_pin_lvl = agree_level(pin_s2_ff, pin_s3_ff, pin_lvl_ff);
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         pin_s3_ff <= '0;
         pin_lvl_ff <= '0;
      end else begin
         pin_s1_ff <= {boost_manual, reference_input, pll_lock};
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         pin_lvl_ff <= nxt_pin_lvl;
      end
   end

   // latch decode
   logic [WORD_W-1:0] ctrl_ff, tx_ff, cal_ff, lo_ff;
   logic [WORD_W-1:0] nxt_ctrl, nxt_tx, nxt_cal, nxt_lo;
   logic [PH_W-1:0] phase_ff, nxt_phase;
   logic [TMOD_W-1:0] tmod_ff, nxt_tmod;
   logic [BSC_W-1:0] bsc_ff, nxt_bsc;
   logic cal_start_ff, nxt_cal_start;
   logic sel_ctrl, sel_tx, sel_cal, sel_lo;

   always_comb begin
      sel_ctrl = word_bus.load
                 && word_bus.word[SEL2_W-1:0] == SEL2_CONTROL;
      sel_lo = word_bus.load && word_bus.word[SEL2_W-1:0] == SEL2_LO;
      sel_tx = word_bus.load && word_bus.word[SEL3_W-1:0] == SEL3_TX;
      sel_cal = word_bus.load
                && word_bus.word[SEL3_W-1:0] == SEL3_CAL;
      nxt_ctrl = sel_ctrl ? word_bus.word : ctrl_ff;
      nxt_lo = sel_lo ? word_bus.word : lo_ff;
      nxt_tx = sel_tx ? word_bus.word : tx_ff;
      nxt_cal = sel_cal ? word_bus.word : cal_ff;
      nxt_phase = phase_ff;
      nxt_tmod = tmod_ff;
      nxt_bsc = bsc_ff;
      if (sel_tx || sel_cal) begin
         nxt_phase = word_bus.word[PH_POS +: PH_W];
         nxt_tmod = word_bus.word[TMOD_POS +: TMOD_W];
         nxt_bsc = word_bus.word[BSC_POS +: BSC_W];
      end
      nxt_cal_start = sel_cal && word_bus.word[CAL_TRIG];
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ctrl_ff <= '0;
         tx_ff <= '0;
         cal_ff <= '0;
         lo_ff <= '0;
         phase_ff <= '0;
         tmod_ff <= '0;
         bsc_ff <= '0;
         cal_start_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         tx_ff <= nxt_tx;
         cal_ff <= nxt_cal;
         lo_ff <= nxt_lo;
         phase_ff <= nxt_phase;
         tmod_ff <= nxt_tmod;
         bsc_ff <= nxt_bsc;
         cal_start_ff <= nxt_cal_start;
      end
   end

   // derived outputs
   logic lo_en_ff, nxt_lo_en, tx_en_ff, nxt_tx_en;
   logic [CPI_W-1:0] pump_cur_ff, nxt_pump_cur;
   logic mix_i_ff, nxt_mix_i, mix_q_ff, nxt_mix_q;

   always_comb begin
      nxt_lo_en = !(ctrl_ff[CTL_LOMUTE] && !pin_lvl_ff[PIN_LOCK])
                  && phase_ff != RX_LO_OFF;
      nxt_tx_en = !(ctrl_ff[CTL_TXMUTE] && !pin_lvl_ff[PIN_LOCK]);
      nxt_pump_cur = lo_ff[LO_GAIN] ? CPI_MAX
                     : ctrl_ff[CTL_CPI +: CPI_W];
      case (tmod_ff)
         TMOD_BOTH_I: begin
            nxt_mix_i = MIX_I;
            nxt_mix_q = MIX_I;
         end
         TMOD_BOTH_Q: begin
            nxt_mix_i = MIX_Q;
            nxt_mix_q = MIX_Q;
         end
         default: begin
            nxt_mix_i = MIX_I;
            nxt_mix_q = MIX_Q;
         end
      endcase
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         lo_en_ff <= 1'b0;
         tx_en_ff <= 1'b0;
         pump_cur_ff <= '0;
         mix_i_ff <= MIX_I;
         mix_q_ff <= MIX_Q;
      end else begin
         lo_en_ff <= nxt_lo_en;
         tx_en_ff <= nxt_tx_en;
         pump_cur_ff <= nxt_pump_cur;
         mix_i_ff <= nxt_mix_i;
         mix_q_ff <= nxt_mix_q;
      end
   end

   // calibration clock divider
   logic [CAL_DIV_W-1:0] div_cnt_ff, nxt_div_cnt, cal_div;
   logic tick_ff, nxt_tick, ref_rise;

   always_comb begin
      ref_rise = nxt_pin_lvl[PIN_REF] & ~pin_lvl_ff[PIN_REF];
      cal_div = cal_ff[CAL_DIV_POS +: CAL_DIV_W];
      nxt_div_cnt = div_cnt_ff;
      nxt_tick = 1'b0;
      if (cal_div == '0) begin
         nxt_div_cnt = '0;
      end else if (ref_rise) begin
         if (div_cnt_ff >= cal_div - 6'h1) begin
            nxt_div_cnt = '0;
            nxt_tick = 1'b1;
         end else begin
            nxt_div_cnt = div_cnt_ff + 6'h1;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         div_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         tick_ff <= nxt_tick;
      end
   end

   // high-pass boost timer
   sfcl_boost_t boost_state_ff, nxt_boost_state;
   logic [CAL_TO_W-1:0] boost_cnt_ff, nxt_boost_cnt, new_timeout;
   logic boost_ff, nxt_boost;

   always_comb begin
      new_timeout = word_bus.word[CAL_TO_POS +: CAL_TO_W];
      nxt_boost_state = boost_state_ff;
      nxt_boost_cnt = boost_cnt_ff;
      case (boost_state_ff)
         BOOST_IDLE: begin
            nxt_boost_cnt = '0;
         end
         BOOST_RUN: begin
            if (tick_ff) begin
               if (boost_cnt_ff == 6'h1) begin
                  nxt_boost_state = BOOST_IDLE;
                  nxt_boost_cnt = '0;
               end else begin
                  nxt_boost_cnt = boost_cnt_ff - 6'h1;
               end
            end
         end
         default: begin
            nxt_boost_state = BOOST_IDLE;
            nxt_boost_cnt = '0;
         end
      endcase
      if (sel_cal) begin
         if (new_timeout != '0) begin
            nxt_boost_state = BOOST_RUN;
            nxt_boost_cnt = new_timeout;
         end else begin
            nxt_boost_state = BOOST_IDLE;
            nxt_boost_cnt = '0;
         end
      end
      nxt_boost = boost_state_ff == BOOST_RUN
                  || (cal_ff[CAL_TO_POS +: CAL_TO_W] == '0
                      && pin_lvl_ff[PIN_MAN]);
   end
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         boost_state_ff <= BOOST_IDLE;
         boost_cnt_ff <= '0;
         boost_ff <= 1'b0;
      end else begin
         boost_state_ff <= nxt_boost_state;
         boost_cnt_ff <= nxt_boost_cnt;
         boost_ff <= nxt_boost;
      end
   end

   // output map
   assign rx_filter_powerdown = ctrl_ff[CTL_RXF_OFF];
   assign synth_powerdown = ctrl_ff[CTL_SYN_OFF];
   assign oscillator_powerdown = ctrl_ff[CTL_OSC_OFF];
   assign transmit_powerdown = ctrl_ff[CTL_TX_OFF];
   assign lo_output_enable = lo_en_ff;
   assign tx_output_enable = tx_en_ff;
   assign pump_tristate = ctrl_ff[CTL_TRI];
   assign phase_polarity = ctrl_ff[CTL_POL];
   assign counter_hold = ctrl_ff[CTL_HOLD];
   assign mux_select = ctrl_ff[CTL_MUX +: MUX_W];
   assign tx_power_level = ctrl_ff[CTL_TXPWR +: PWR_W];
   assign lo_power_level = ctrl_ff[CTL_LOPWR +: PWR_W];
   assign rx_lo_phase_field = phase_ff;
   assign tx_mix_i_phase = mix_i_ff;
   assign tx_mix_q_phase = mix_q_ff;
   assign band_clock_divider = bsc_ff;
   assign reference_divider = tx_ff[TX_REF_POS +: REF_W];
   assign calibration_start = cal_start_ff;
   assign calibration_clock_tick = tick_ff;
   assign boost_active = boost_ff;
   assign prescaler_select = lo_ff[LO_PRE_POS +: PRE_W];
   assign pump_current = pump_cur_ff;
   assign feedback_select = lo_ff[LO_FB];
   assign b_counter_field = lo_ff[LO_B_POS +: B_W];
   assign a_counter_field = lo_ff[LO_A_POS +: A_W];

   a_ctrl_decode: assert property (
      @(posedge clock) disable iff (!reset_n)
      (word_bus.load && word_bus.word[SEL2_W-1:0] == SEL2_CONTROL)
      |=> ctrl_ff == $past(word_bus.word))
      else $error("control latch not loaded");
   a_tx_decode: assert property (
      @(posedge clock) disable iff (!reset_n)
      (word_bus.load && word_bus.word[SEL3_W-1:0] == SEL3_TX)
      |=> tx_ff == $past(word_bus.word) && ctrl_ff == $past(ctrl_ff))
      else $error("transmit latch not loaded");
   a_cal_decode: assert property (
      @(posedge clock) disable iff (!reset_n)
      (word_bus.load && word_bus.word[SEL3_W-1:0] == SEL3_CAL)
      |=> cal_ff == $past(word_bus.word) && tx_ff == $past(tx_ff))
      else $error("calibration latch not loaded");
   a_lo_decode: assert property (
      @(posedge clock) disable iff (!reset_n)
      (word_bus.load && word_bus.word[SEL2_W-1:0] == SEL2_LO)
      |=> lo_ff == $past(word_bus.word))
      else $error("local_osc_latch not loaded");
   a_lo_mute_lock: assert property (
      @(posedge clock) disable iff (!reset_n)
      (ctrl_ff[CTL_LOMUTE] && !pin_lvl_ff[PIN_LOCK]) |=> !lo_output_enable)
      else $error("lo output on before lock");
   a_tx_mute_lock: assert property (
      @(posedge clock) disable iff (!reset_n)
      (ctrl_ff[CTL_TXMUTE] && !pin_lvl_ff[PIN_LOCK]) |=> !tx_output_enable)
      else $error("tx output on before lock");
   a_cal_trigger: assert property (
      @(posedge clock) disable iff (!reset_n)
      ##1 calibration_start == $past(sel_cal && word_bus.word[CAL_TRIG]))
      else $error("calibration start mismatch");
   a_pump_gain_max: assert property (
      @(posedge clock) disable iff (!reset_n)
      lo_ff[LO_GAIN] |=> pump_current == CPI_MAX)
      else $error("pump gain not at maximum");
   a_boost_load: assert property (
      @(posedge clock) disable iff (!reset_n)
      (sel_cal && new_timeout != '0)
      |=> boost_state_ff == BOOST_RUN ##1 boost_active)
      else $error("boost did not start");
   a_boost_end: assert property (
      @(posedge clock) disable iff (!reset_n)
      (boost_state_ff == BOOST_RUN && boost_cnt_ff == 6'h1 && tick_ff
       && !sel_cal) |=> boost_state_ff == BOOST_IDLE)
      else $error("boost overran its timeout");
   a_boost_manual: assert property (
      @(posedge clock) disable iff (!reset_n)
      (boost_state_ff == BOOST_IDLE && cal_ff[CAL_TO_POS +: CAL_TO_W] == '0)
      |=> boost_active == $past(pin_lvl_ff[PIN_MAN]))
      else $error("manual boost not followed");
   a_cal_tick_gap: assert property (
      @(posedge clock) disable iff (!reset_n)
      (tick_ff && cal_div > 6'h1 && !sel_cal) |=> !tick_ff)
      else $error("calibration ticks too close");

endmodule

// ==== tb/sfcl_host_model.sv ====
module sfcl_host_model (
   input wire logic clock,
   output logic serial_clock,
   output logic serial_in,
   output logic load_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 5;
   initial begin
      serial_clock = 1'b0;
      serial_in = 1'b1;
      load_enable = 1'b0;
   end
   // msb first, clock idles low between frames
   task automatic write_word(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         serial_in <= w[i];
         @(posedge clock);
         serial_clock <= 1'b1;
         repeat (HOLD) @(posedge clock);
         serial_clock <= 1'b0;
         repeat (HOLD) @(posedge clock);
      end
      // released data line shows the inverse
      serial_in <= ~w[0];
      load_enable <= 1'b1;
      repeat (HOLD) @(posedge clock);
      load_enable <= 1'b0;
      repeat (HOLD) @(posedge clock);
   endtask
endmodule

// ==== tb/sfcl_latches_bench.sv ====
module sfcl_latches_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import sfcl_pkg::*;
   localparam int LIMIT = 20000;
   logic clock, reset_n, serial_clock, serial_in, load_enable;
   logic pll_lock, boost_manual;
   logic reference_input = 1'b0;
   logic rx_filter_powerdown, synth_powerdown, oscillator_powerdown;
   logic transmit_powerdown, lo_output_enable, tx_output_enable;
   logic pump_tristate, phase_polarity, counter_hold, tx_mix_i_phase;
   logic tx_mix_q_phase, calibration_start, calibration_clock_tick;
   logic boost_active, feedback_select;
   logic [2:0] mux_select, rx_lo_phase_field, pump_current;
   logic [1:0] tx_power_level, lo_power_level, band_clock_divider;
   logic [1:0] prescaler_select, mx;
   logic [12:0] reference_divider, b_counter_field, r;
   logic [4:0] a_counter_field;
   logic [23:0] w, cl;
   logic [23:0] cw [2] = '{24'h2ab6d0, 24'h55492f};
   logic [23:0] lw [2] = '{24'hfffffe, 24'h400182};
   int miscompares = 0, cmp_count = 0, cycles = 0;
   int starts = 0, ticks = 0, bticks = 0, n0, t0;
   wire [3:0] pd = {rx_filter_powerdown, synth_powerdown,
      oscillator_powerdown, transmit_powerdown};

   sfcl_latches dut (.clock, .reset_n, .serial_clock, .serial_in,
      .load_enable, .pll_lock, .reference_input, .boost_manual,
      .rx_filter_powerdown, .synth_powerdown, .oscillator_powerdown,
      .transmit_powerdown, .lo_output_enable, .tx_output_enable,
      .pump_tristate, .phase_polarity, .counter_hold, .mux_select,
      .tx_power_level, .lo_power_level, .rx_lo_phase_field,
      .tx_mix_i_phase, .tx_mix_q_phase, .band_clock_divider,
      .reference_divider, .calibration_start, .calibration_clock_tick,
      .boost_active, .prescaler_select, .pump_current,
      .feedback_select, .b_counter_field, .a_counter_field);
   sfcl_host_model host (.clock, .serial_clock, .serial_in, .load_enable);

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // pulse counters, reference clock, hang guard
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (calibration_start === 1'b1) starts <= starts + 1;
      if (calibration_clock_tick === 1'b1) ticks <= ticks + 1;
      if (calibration_clock_tick === 1'b1 && boost_active === 1'b1)
         bticks <= bticks + 1;
      if (cycles % 5 == 4) reference_input <= ~reference_input;
      if (cycles == LIMIT) begin
         miscompares++;
         $display("[FAIL] %0t timeout", $time);
         complete_run();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [23:0] x);
      host.write_word(x);
      repeat (2) @(posedge clock);
   endtask

   initial begin
      reset_n = 1'b0;
      pll_lock = 1'b1;
      boost_manual = 1'b0;
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      repeat (2) @(posedge clock);
      chk({pd, b_counter_field, reference_divider}, 0);
      chk({tx_mix_q_phase, lo_output_enable, tx_output_enable}, 3'h7);
      repeat (6) @(posedge clock);
      $display("reset test done");

      pll_lock <= 1'b0;
      wr(24'h000184);
      chk({lo_output_enable, tx_output_enable}, 2'h0);
      pll_lock <= 1'b1;
      repeat (8) @(posedge clock);
      chk({lo_output_enable, tx_output_enable}, 2'h3);
      pll_lock <= 1'b0;
      wr(24'h000004);
      chk({lo_output_enable, tx_output_enable}, 2'h3);
      pll_lock <= 1'b1;
      $display("mute test done");

      foreach (cw[i]) begin
         cl = {cw[i][23:4], 4'h4};
         wr(cl);
         chk(pd, cl[CTL_RXF_OFF:CTL_TX_OFF]);
         chk(pump_tristate, cl[CTL_TRI]);
         chk(phase_polarity, cl[CTL_POL]);
         chk(counter_hold, cl[CTL_HOLD]);
         chk(pump_current, cl[CTL_CPI+:CPI_W]);
         chk({mux_select, tx_power_level, lo_power_level},
            {cl[11:9], cl[16:15], cl[18:17]});
      end
      $display("control test done");

      for (int t = 0; t < 8; t++) begin
         r = (t == 0) ? 13'h1 : (t == 7) ? 13'h1fff : {t[2:0], 10'h155};
         mx = (t[2:0] == TMOD_BOTH_I) ? {MIX_I, MIX_I} :
            (t[2:0] == TMOD_BOTH_Q) ? {MIX_Q, MIX_Q} : {MIX_I, MIX_Q};
         wr({t[2:0], t[2:0], 2'h3, r, 3'h1});
         chk(reference_divider, r);
         chk(rx_lo_phase_field, t[2:0]);
         chk(lo_output_enable, t[2:0] != RX_LO_OFF);
         chk({tx_mix_i_phase, tx_mix_q_phase}, mx);
         chk(band_clock_divider, 2'h3);
      end
      $display("transmit test done");

      foreach (lw[i]) begin
         wr(lw[i]);
         chk(prescaler_select, lw[i][23:22]);
         chk(feedback_select, lw[i][LO_FB]);
         chk(b_counter_field, lw[i][19:7]);
         chk(a_counter_field, lw[i][6:2]);
         chk(pump_current, lw[i][LO_GAIN] ? CPI_MAX : cl[14:12]);
      end
      wr(24'hffffff);
      chk({pd, b_counter_field}, {cl[22:19], 13'h3});
      chk(reference_divider, 13'h1fff);
      $display("lo test done");

      n0 = starts;
      t0 = bticks;
      wr({3'h2, 3'h0, 2'h3, 1'b1, 6'h2, 6'h3, 3'h5});
      chk(starts, n0 + 1);
      chk(rx_lo_phase_field, 3'h2);
      chk(boost_active, 1'b1);
      repeat (150) @(posedge clock);
      chk(boost_active, 1'b0);
      chk(bticks, t0 + 3);
      t0 = ticks;
      repeat (400) @(posedge clock);
      chk(ticks - t0 inside {[19:21]}, 1'b1);
      n0 = starts;
      wr({3'h0, 3'h0, 2'h3, 1'b0, 6'h2, 6'h0, 3'h5});
      chk(starts, n0);
      chk(boost_active, 1'b0);
      boost_manual <= 1'b1;
      repeat (8) @(posedge clock);
      chk(boost_active, 1'b1);
      boost_manual <= 1'b0;
      repeat (8) @(posedge clock);
      chk(boost_active, 1'b0);
      $display("calibration test done");
      complete_run();
   end
endmodule
